// >>> rtl/irq_cfg_params.svh
// Offsets, field positions, reset values and timing counts of the interrupt configuration
`ifndef IRQ_CFG_PARAMS_SVH
`define IRQ_CFG_PARAMS_SVH

`define ICFG_ADDR 12'h04C
`define ICFG_RESET 32'h0000_0000
`define ICFG_MASK_HI 31
`define ICFG_MASK_LO 25
`define ICFG_EN_TIMEOUT 20
`define ICFG_EN_INTERLOCK 19
`define ICFG_EN_RMW2 18
`define ICFG_EN_RMW1 17
`define ICFG_MAP_HI 16
`define ICFG_MAP_LO 14
`define IPL_BASE 5'h14
`define SYNC_STAGES 3
`define CLK_PERIOD_NS 8

`endif

// >>> rtl/irq_cfg_pkg.sv
// Types shared by the interrupt configuration block
package irq_cfg_pkg;
    typedef struct packed {
        logic [6:0] level_mask;
        logic en_timeout;
        logic en_interlock;
        logic en_rmw2;
        logic en_rmw1;
        logic [2:0] irq7_map;
    } cfg_s;

    typedef struct packed {
        logic timeout;
        logic interlock;
        logic rmw2;
        logic rmw1;
    } err_evt_s;

    typedef enum {
        host_request_line_four,
        host_request_line_five,
        host_request_line_six,
        host_request_line_seven
    } host_line_e;
endpackage : irq_cfg_pkg

// >>> rtl/pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 11
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] pin_i,
    input wire logic [WIDTH-1:0] reset_val_i,
    output logic [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("pin_sync needs WIDTH of at least one");
        end
    endgenerate

    always_ff @(posedge ref_clk_i) begin
        stage1 <= pin_i;
        stage2 <= stage1;
        stage3 <= stage2;
    end

    // Strap-style reset value is taken by the clocked process
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            level_o <= reset_val_i;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    level_o[i] <= stage3[i];
                end
            end
        end
    end
endmodule : pin_sync

// >>> rtl/irq_cfg_top.sv
// Interrupt configuration register: error interrupt enables, level mask and IRQ7 routing
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "irq_cfg_params.svh"
module irq_cfg_top #(
    parameter int ADDR_W = 12
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic hsel_i,
    input wire logic [ADDR_W-1:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire irq_cfg_pkg::err_evt_s err_evt_i,
    input wire logic [7:1] vme_irq_n_i,
    output logic err_irq_o,
    output irq_cfg_pkg::err_evt_s err_cause_o,
    output logic [7:1] vme_level_req_o,
    output logic [3:0] host_request_line_o,
    output logic [4:0] irq7_priority_level_o,
    output logic irq7_rora_o
);
    import irq_cfg_pkg::*;

    cfg_s cfg;
    cfg_s next_cfg;
    logic wr_pend;
    logic addr_hit;
    logic rd_req;
    logic [10:0] synced;
    err_evt_s evt;
    err_evt_s evt_q;
    err_evt_s rise;
    err_evt_s en_vec;
    logic [7:1] vme_act;
    host_line_e irq7_line;

    generate
        if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
            $error("irq_cfg_top needs ADDR_W between 8 and 32");
        end
    endgenerate

    assign addr_hit = (haddr_i == ADDR_W'(`ICFG_ADDR));
    assign rd_req = hsel_i && hready_i && htrans_i[1] && !hwrite_i;

    // Write address phase; the data phase stores into the register
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            wr_pend <= 1'b0;
        end else if (hready_i) begin
            wr_pend <= hsel_i && htrans_i[1] && hwrite_i && addr_hit;
        end
    end

    always_comb begin
        next_cfg = cfg;
        if (wr_pend) begin
            next_cfg.level_mask = hwdata_i[`ICFG_MASK_HI:`ICFG_MASK_LO];
            next_cfg.en_timeout = hwdata_i[`ICFG_EN_TIMEOUT];
            next_cfg.en_interlock = hwdata_i[`ICFG_EN_INTERLOCK];
            next_cfg.en_rmw2 = hwdata_i[`ICFG_EN_RMW2];
            next_cfg.en_rmw1 = hwdata_i[`ICFG_EN_RMW1];
            next_cfg.irq7_map = hwdata_i[`ICFG_MAP_HI:`ICFG_MAP_LO];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            cfg <= cfg_s'(0);
        end else begin
            cfg <= next_cfg;
        end
    end

    // Read data is built from next_cfg so a read right behind a write sees it
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            hrdata_o <= `ICFG_RESET;
        end else if (rd_req) begin
            hrdata_o <= 32'h0000_0000;
            if (addr_hit) begin
                hrdata_o[`ICFG_MASK_HI:`ICFG_MASK_LO] <= next_cfg.level_mask;
                hrdata_o[`ICFG_EN_TIMEOUT] <= next_cfg.en_timeout;
                hrdata_o[`ICFG_EN_INTERLOCK] <= next_cfg.en_interlock;
                hrdata_o[`ICFG_EN_RMW2] <= next_cfg.en_rmw2;
                hrdata_o[`ICFG_EN_RMW1] <= next_cfg.en_rmw1;
                hrdata_o[`ICFG_MAP_HI:`ICFG_MAP_LO] <= next_cfg.irq7_map;
            end
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            hreadyout_o <= 1'b0;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    pin_sync #(.WIDTH(11)) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .pin_i({vme_irq_n_i, err_evt_i}),
        .reset_val_i({7'h7F, 4'h0}),
        .level_o(synced)
    );

    assign evt = synced[3:0];
    assign vme_act = ~synced[10:4];
    assign rise = evt & ~evt_q;
    assign en_vec = {cfg.en_timeout, cfg.en_interlock, cfg.en_rmw2, cfg.en_rmw1};

    // Error events are flagged on their rising edge and gated by the live enables
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            evt_q <= err_evt_s'(0);
            err_cause_o <= err_evt_s'(0);
            err_irq_o <= 1'b0;
        end else begin
            evt_q <= evt;
            err_cause_o <= rise & en_vec;
            err_irq_o <= |(rise & en_vec);
        end
    end

    always_comb begin
        case (cfg.irq7_map[2:1])
            2'h0: irq7_line = host_request_line_four;
            2'h1: irq7_line = host_request_line_five;
            2'h2: irq7_line = host_request_line_six;
            default: irq7_line = host_request_line_seven;
        endcase
    end

    // Level mask gates each VME level; IRQ7 is routed to its chosen request line
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            vme_level_req_o <= 7'h00;
            host_request_line_o <= 4'h0;
            irq7_priority_level_o <= `IPL_BASE;
            irq7_rora_o <= 1'b0;
        end else begin
            // Mask bit 6 (register bit 31) belongs to IRQ7, mask bit 0 to IRQ1
            vme_level_req_o <= vme_act & cfg.level_mask;
            host_request_line_o <= 4'h0;
            if (vme_act[7] && cfg.level_mask[6]) begin
                host_request_line_o[irq7_line] <= 1'b1;
            end
            irq7_priority_level_o <= `IPL_BASE + 5'(cfg.irq7_map[2:1]);
            irq7_rora_o <= cfg.irq7_map[0];
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    a_timeout_irq: assert property (rise.timeout && cfg.en_timeout
        |=> err_irq_o && err_cause_o.timeout)
        else $error("enabled timeout did not interrupt");
    a_interlock_irq: assert property (rise.interlock && cfg.en_interlock
        |=> err_irq_o && err_cause_o.interlock)
        else $error("enabled interlock error did not interrupt");
    a_rmw2_irq: assert property (rise.rmw2 && cfg.en_rmw2
        |=> err_irq_o && err_cause_o.rmw2)
        else $error("enabled second read-modify-write error did not interrupt");
    a_rmw1_irq: assert property (rise.rmw1 && cfg.en_rmw1
        |=> err_irq_o && err_cause_o.rmw1)
        else $error("enabled first read-modify-write error did not interrupt");
    a_irq7_line: assert property (vme_act[7] && cfg.level_mask[6]
        |=> host_request_line_o == (4'h1 << $past(cfg.irq7_map[2:1]))
        && irq7_priority_level_o == `IPL_BASE + 5'($past(cfg.irq7_map[2:1])))
        else $error("IRQ7 routed to wrong request line");
    a_irq7_type: assert property (##1 irq7_rora_o == $past(cfg.irq7_map[0], 2)
        || $past(wr_pend, 2) || $past(wr_pend))
        else $error("IRQ7 interrupter type does not follow map bit");
    a_reset_zero: assert property (@(posedge ref_clk_i) disable iff (1'b0)
        reset_i |=> cfg == cfg_s'(0) && host_request_line_o == 4'h0
        && !irq7_rora_o)
        else $error("configuration not zero after reset");
    a_level_mask: assert property (##1 (vme_level_req_o[7] && !$past(cfg.level_mask[6]))
        == 1'b0 && (vme_level_req_o[1] && !$past(cfg.level_mask[0])) == 1'b0)
        else $error("masked VME level passed");
    a_disabled_quiet: assert property ((en_vec == 4'h0) |=> !err_irq_o
        && err_cause_o == err_evt_s'(0))
        else $error("disabled error event interrupted");
    a_write_effect: assert property (wr_pend |=> cfg.en_timeout
        == $past(hwdata_i[`ICFG_EN_TIMEOUT]) && cfg.irq7_map
        == $past(hwdata_i[`ICFG_MAP_HI:`ICFG_MAP_LO]))
        else $error("register write did not take effect next cycle");

    c_timeout_irq: cover property (rise.timeout && cfg.en_timeout ##1 err_irq_o);
    c_masked_event: cover property (rise.rmw1 && !cfg.en_rmw1);
    c_irq7_line_seven: cover property (host_request_line_o[3] && !irq7_rora_o);
    c_read_after_write: cover property (wr_pend && rd_req && addr_hit);
    c_irq7_masked: cover property (vme_act[7] && !cfg.level_mask[6]);
endmodule : irq_cfg_top

// >>> verif/event_source.sv
// Model of the error event sources and VME interrupters that feed the block
`timescale 1ns/1ps
module event_source (
    input wire logic ref_clk_i,
    input wire logic [3:0] fire_i,
    input wire logic [7:1] irq_req_i,
    output irq_cfg_pkg::err_evt_s err_evt_o,
    output logic [7:1] vme_irq_n_o
);
    import irq_cfg_pkg::*;
    logic [3:0] held;
    // Stretch each event to two cycles so the synchroniser's agreement filter sees it
    always_ff @(posedge ref_clk_i) begin
        held <= fire_i;
        err_evt_o <= err_evt_s'(fire_i | held);
    end
    // Interrupt request lines are active low and idle high when released
    always_ff @(posedge ref_clk_i) begin
        vme_irq_n_o <= ~irq_req_i;
    end
endmodule : event_source

// >>> verif/irq_cfg_top_tb.sv
// Self-checking testbench of the interrupt configuration register
`timescale 1ns/1ps
`include "irq_cfg_params.svh"
module irq_cfg_top_tb;
    import irq_cfg_pkg::*;
    typedef struct packed {logic [31:0] cfg; logic [3:0] evt;} row_s;
    localparam row_s ROWS [8] = '{'{32'h8010_0000, 4'h8}, '{32'hC008_4000, 4'hC},
        '{32'h0004_8000, 4'hF}, '{32'hFE02_C000, 4'h3}, '{32'h801F_0000, 4'h6},
        '{32'hAA01_4000, 4'hF}, '{32'h8001_8000, 4'hF}, '{32'hFFFF_FFFF, 4'hF}};
    logic ref_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic [3:0] fire = 4'h0, line;
    logic [7:1] irq_req = 7'h00, irq_n, lvl_req;
    logic [4:0] lvl;
    logic hresp, err_irq, rora;
    err_evt_s evt, cause;
    int fails = 0, checks_done = 0, cycles = 0;
    irq_cfg_top i_dut (.ref_clk_i(ref_clk), .reset_i(reset), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .err_evt_i(evt), .vme_irq_n_i(irq_n), .err_irq_o(err_irq), .err_cause_o(cause),
        .vme_level_req_o(lvl_req), .host_request_line_o(line),
        .irq7_priority_level_o(lvl), .irq7_rora_o(rora));
    event_source i_src (.ref_clk_i(ref_clk), .fire_i(fire), .irq_req_i(irq_req),
        .err_evt_o(evt), .vme_irq_n_o(irq_n));
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    task finish_test();
        if (fails == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
            fails++;
        end
    endtask : check
    task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
        check(32'(hresp), 32'h0);
    endtask : ahb
    // Fires events, then collects the cause and the number of interrupt pulses
    task send_evt(input logic [3:0] e, input logic [3:0] exp);
        logic [3:0] got;
        int n;
        got = 4'h0;
        n = 0;
        @(posedge ref_clk) fire <= e;
        @(posedge ref_clk) fire <= 4'h0;
        repeat (12) begin
            @(posedge ref_clk);
            if (err_irq === 1'b1) begin
                got = cause;
                n++;
            end
        end
        check(32'(got), 32'(exp));
        check(32'(n), 32'(exp != 4'h0));
    endtask : send_evt
    task reset_checks();
        reset <= 1'b1;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        ahb(1'b0, `ICFG_ADDR, 32'h0);
        check(rd, 32'h0);
        check(32'(lvl), 32'h14);
        check(32'(rora), 32'h0);
    endtask : reset_checks
    initial begin
        reset_checks();
        irq_req <= 7'h7F;
        ahb(1'b1, `ICFG_ADDR, 32'hFE01_8000);
        send_evt(4'hF, 4'h0);
        check(32'(line), 32'h8);
        foreach (ROWS[i]) begin
            ahb(1'b1, `ICFG_ADDR, ROWS[i].cfg);
            send_evt(ROWS[i].evt, ROWS[i].evt & ROWS[i].cfg[20:17]);
            ahb(1'b0, `ICFG_ADDR, 32'h0);
            check(rd, ROWS[i].cfg & 32'hFE1F_C000);
            check(32'(line), ROWS[i].cfg[31] ? 32'h1 << ROWS[i].cfg[16:15] : 32'h0);
            check(32'(lvl), 32'h14 + 32'(ROWS[i].cfg[16:15]));
            check(32'(rora), 32'(ROWS[i].cfg[14]));
            check(32'(lvl_req), 32'(ROWS[i].cfg[31:25]));
        end
        ahb(1'b1, 12'h050, 32'hFFFF_FFFF);
        ahb(1'b0, 12'h050, 32'h0);
        check(rd, 32'h0);
        ahb(1'b0, `ICFG_ADDR, 32'h0);
        check(rd, 32'hFE1F_C000);
        reset_checks();
        send_evt(4'hF, 4'h0);
        finish_test();
    end
endmodule : irq_cfg_top_tb
